/* design/otfr_over_temp_fault_response.sv */
// module: over-temperature limits, response setting and fault sequencer
`timescale 1ns/1ns
// Operation
// RULE1: fault threshold, 16 bits, command 0x4F
// RULE2: warning threshold, 16 bits, command 0x51
// RULE3: reaction bits 7:6; 00 ignores fault
// RULE4: continue for delay, then retry setting
// RULE5: reaction 10 disables at once, retries
// RULE6: reaction 11 latches off until cleared
// RULE7: retry 000 means no restart, stay off
// RULE8: retries 1..6, then latch off
// RULE9: restart spacing is delay times unit
// RULE10: retry 111 retries until commanded off
// RULE11: delay field decodes to 2**code units
// RULE12: unit length from configuration register 0xC8; the code takes it from the continue_unit_cycles and restart_unit_cycles inputs
// RULE13: reaction 01 selects continue-then-retry
// RULE14: warn above warning, fault above fault threshold
module otfr_over_temp_fault_response
   import otfr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_data,
   input wire logic [7:0] rd_code,
   output logic [15:0] rd_data,
   input wire logic clear_faults,
   input wire logic clear_status_bit,
   input wire logic output_on_cmd,
   input wire logic [15:0] temperature,
   input wire logic [UNIT_W-1:0] continue_unit_cycles,
   input wire logic [UNIT_W-1:0] restart_unit_cycles,
   input wire logic restart_ok,
   input wire logic other_fault,
   output logic output_enable,
   output logic over_temp_warning,
   output logic over_temp_fault,
   output logic restart_attempt
);
   logic [15:0] over_temp_fault_threshold; // fault limit
   logic [15:0] over_temp_warning_threshold; // warning limit
   logic [7:0] over_temp_fault_action; // response byte
   otfr_state_type state; // sequencer state
   otfr_state_type next_state; // next sequencer state
   logic [2:0] tries_used; // restarts made so far
   logic on_cmd_d; // last on command level
   logic fault_now; // temperature over fault limit
   logic warn_now; // temperature over warning limit
   logic fault_clear; // any clear source
   logic [1:0] react; // reaction field
   logic [2:0] retries; // retry field
   logic [2:0] delay_code; // delay field
   logic [8:0] delay_units; // decoded unit count
   logic retries_left; // another restart allowed
   otfr_timer_if tif ();

   otfr_delay_timer u_timer (
      .clk(clk),
      .arst_n(arst_n),
      .tmr(tif.timer)
   );

   // threshold comparisons, simple unsigned compare of the raw words
   assign fault_now = temperature > over_temp_fault_threshold; // [RULE14]
   assign warn_now = temperature > over_temp_warning_threshold; // [RULE14]
   assign react = over_temp_fault_action[REACT_MSB:REACT_LSB]; // [RULE3]
   assign retries = over_temp_fault_action[RETRY_MSB:RETRY_LSB];
   assign delay_code = over_temp_fault_action[DELAY_MSB:DELAY_LSB];
   assign delay_units = 9'h1 << delay_code; // [RULE11]
   // off-then-on: a rising on command after an off clears the latch
   assign fault_clear = clear_faults || clear_status_bit || (output_on_cmd && !on_cmd_d); // [RULE6]
   // unlimited retries stop only on command off or another fault
   assign retries_left = (retries == RETRY_FOREVER) || (tries_used < retries); // [RULE10] [RULE8]

   // settings written by the host command port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         over_temp_fault_threshold <= RST_FAULT_THRESHOLD;
         over_temp_warning_threshold <= RST_WARNING_THRESHOLD;
         over_temp_fault_action <= RST_FAULT_ACTION;
      end else if (cmd_write) begin
         case (cmd_code)
            CMD_OT_FAULT_THRESHOLD: over_temp_fault_threshold <= cmd_data; // [RULE1]
            CMD_OT_WARNING_THRESHOLD: over_temp_warning_threshold <= cmd_data; // [RULE2]
            CMD_OT_FAULT_ACTION: over_temp_fault_action <= cmd_data[7:0];
            default: ;
         endcase
      end
   end

   // read-back mux; unknown codes read zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else begin
         case (rd_code)
            CMD_OT_FAULT_THRESHOLD: rd_data <= over_temp_fault_threshold;
            CMD_OT_WARNING_THRESHOLD: rd_data <= over_temp_warning_threshold;
            CMD_OT_FAULT_ACTION: rd_data <= {8'h00, over_temp_fault_action};
            default: rd_data <= '0;
         endcase
      end
   end

   // edge memory of the on command
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         on_cmd_d <= 1'b0;
      end else begin
         on_cmd_d <= output_on_cmd;
      end
   end

   // sequencer next state
   always_comb begin
      next_state = state;
      tif.load = 1'b0;
      tif.cycles = '0;
      case (state)
         OTFR_IDLE: begin
            if (fault_now && output_on_cmd) begin
               case (react)
                  REACT_IGNORE: next_state = OTFR_IDLE; // [RULE3]
                  REACT_CONTINUE: begin
                     next_state = OTFR_CONTINUE; // [RULE13] [RULE4]
                     tif.load = 1'b1;
                     tif.cycles = TIMER_W'(continue_unit_cycles) * TIMER_W'(delay_units); // [RULE12]
                  end
                  REACT_DISABLE_RETRY: begin
                     next_state = OTFR_OFF_WAIT; // [RULE5]
                     tif.load = 1'b1;
                     tif.cycles = TIMER_W'(restart_unit_cycles) * TIMER_W'(delay_units); // [RULE9]
                  end
                  default: next_state = OTFR_LATCHED; // [RULE6]
               endcase
               if (react != REACT_IGNORE && react != REACT_LATCH_OFF && retries == RETRY_NONE
                   && react == REACT_DISABLE_RETRY) begin
                  next_state = OTFR_LATCHED; // [RULE7]
                  tif.load = 1'b0;
               end
            end
         end
         OTFR_CONTINUE: begin
            // output stays on through the delay
            if (!fault_now) begin
               next_state = OTFR_IDLE;
            end else if (tif.expired) begin
               if (retries == RETRY_NONE) begin
                  next_state = OTFR_LATCHED; // [RULE7]
               end else begin
                  next_state = OTFR_OFF_WAIT; // [RULE4]
                  tif.load = 1'b1;
                  tif.cycles = TIMER_W'(restart_unit_cycles) * TIMER_W'(delay_units); // [RULE9]
               end
            end
         end
         OTFR_OFF_WAIT: begin
            // output off; wait one restart spacing
            if (!output_on_cmd || other_fault) begin
               next_state = OTFR_LATCHED; // [RULE10]
            end else if (tif.expired || !tif.running) begin
               next_state = retries_left ? OTFR_RESTART : OTFR_LATCHED; // [RULE8]
               // spacing runs start to start, so it is loaded as the attempt begins;
               // an idle timer here means a span too short to see expire
               tif.load = retries_left;
               tif.cycles = TIMER_W'(restart_unit_cycles) * TIMER_W'(delay_units); // [RULE9]
            end
         end
         OTFR_RESTART: begin
            // one attempt; a start not judged good or fault present counts as failed
            if (restart_ok && !fault_now) begin
               next_state = OTFR_IDLE;
            end else begin
               // timer already counts from this attempt's start
               next_state = OTFR_OFF_WAIT; // [RULE9]
            end
         end
         OTFR_LATCHED: begin
            if (fault_clear) begin
               next_state = OTFR_IDLE; // [RULE6]
            end
         end
         default: next_state = OTFR_IDLE;
      endcase
   end

   // sequencer state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= OTFR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // restart count; cleared whenever the sequence returns to idle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tries_used <= '0;
      end else if (next_state == OTFR_IDLE) begin
         tries_used <= '0;
      end else if (state == OTFR_OFF_WAIT && next_state == OTFR_RESTART && tries_used != 3'h7) begin
         tries_used <= tries_used + 3'h1; // [RULE8]
      end
   end

   // outputs from flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         output_enable <= 1'b0;
         over_temp_warning <= 1'b0;
         over_temp_fault <= 1'b0;
         restart_attempt <= 1'b0;
      end else begin
         output_enable <= output_on_cmd && (next_state == OTFR_IDLE
                          || next_state == OTFR_CONTINUE || next_state == OTFR_RESTART);
         over_temp_warning <= warn_now; // [RULE14]
         over_temp_fault <= fault_now; // [RULE14]
         restart_attempt <= (next_state == OTFR_RESTART) && (state != OTFR_RESTART);
      end
   end
endmodule

/* design/otfr_pkg.sv */
// package: command codes, field layout, reset values and enumerations of the over-temp block
package otfr_pkg;
   // command codes for the settings
   localparam logic [7:0] CMD_OT_FAULT_THRESHOLD = 8'h4f;
   localparam logic [7:0] CMD_OT_FAULT_ACTION = 8'h50;
   localparam logic [7:0] CMD_OT_WARNING_THRESHOLD = 8'h51;
   // response byte field positions
   localparam int REACT_MSB = 7;
   localparam int REACT_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;
   // reaction codes
   localparam logic [1:0] REACT_IGNORE = 2'h0;
   localparam logic [1:0] REACT_CONTINUE = 2'h1;
   localparam logic [1:0] REACT_DISABLE_RETRY = 2'h2;
   localparam logic [1:0] REACT_LATCH_OFF = 2'h3;
   // retry codes
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // reset values of the settings
   localparam logic [15:0] RST_FAULT_THRESHOLD = 16'hffff;
   localparam logic [15:0] RST_WARNING_THRESHOLD = 16'hffff;
   localparam logic [7:0] RST_FAULT_ACTION = 8'hc0;
   // width of the delay-unit length, in clock cycles
   localparam int UNIT_W = 24;
   localparam int TIMER_W = UNIT_W + 8;
   // fault sequencer states
   typedef enum logic [2:0] {
      OTFR_IDLE, OTFR_CONTINUE, OTFR_OFF_WAIT, OTFR_RESTART, OTFR_LATCHED
   } otfr_state_type;
endpackage

/* design/otfr_timer_if.sv */
// interface: load and expiry of the fault delay timer
`timescale 1ns/1ns
interface otfr_timer_if;
   import otfr_pkg::*;
   logic load; // one-cycle start pulse
   logic [TIMER_W-1:0] cycles; // cycles to run
   logic expired; // one-cycle pulse at end
   logic running; // timer busy
   modport ctrl (output load, output cycles, input expired, input running);
   modport timer (input load, input cycles, output expired, output running);
endinterface

/* design/otfr_delay_timer.sv */
// module: down-counter that times the continue delay and restart spacing
`timescale 1ns/1ns
module otfr_delay_timer
   import otfr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   otfr_timer_if.timer tmr
);
   logic [TIMER_W-1:0] count; // cycles left

   // count down after a load; a new load restarts the span
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
      end else if (tmr.load) begin
         count <= tmr.cycles;
      end else if (count != '0) begin
         count <= count - TIMER_W'(1);
      end
   end

   // expiry pulses on the last counted cycle; not gated by load, since the
   // controller decides its load from this pulse and a gate would close a loop
   assign tmr.expired = (count == TIMER_W'(1));
   assign tmr.running = (count != '0);
endmodule

/* dv/otfr_sva.sv */
// checker: timing relations at the over-temp block's ports
`timescale 1ns/1ns
module otfr_sva
   import otfr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_data,
   input wire logic [7:0] rd_code,
   input wire logic [15:0] rd_data,
   input wire logic output_on_cmd,
   input wire logic [15:0] temperature,
   input wire logic [UNIT_W-1:0] continue_unit_cycles,
   input wire logic [UNIT_W-1:0] restart_unit_cycles,
   input wire logic other_fault,
   input wire logic output_enable,
   input wire logic over_temp_warning,
   input wire logic over_temp_fault,
   input wire logic restart_attempt
);
   logic [15:0] warn_sh; // shadow warning threshold
   logic [7:0] act_sh; // shadow response byte
   // shadows follow accepted writes only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         warn_sh <= RST_WARNING_THRESHOLD;
         act_sh <= RST_FAULT_ACTION;
      end else if (cmd_write) begin
         if (cmd_code == CMD_OT_WARNING_THRESHOLD) warn_sh <= cmd_data;
         if (cmd_code == CMD_OT_FAULT_ACTION) act_sh <= cmd_data[7:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // no write and steady input for a cycle
   sequence s_quiet; !cmd_write && $stable(temperature); endsequence
   property p_rd_fault; cmd_write && cmd_code == CMD_OT_FAULT_THRESHOLD ##1 (!cmd_write &&
      rd_code == CMD_OT_FAULT_THRESHOLD)[*3] |-> rd_data == $past(cmd_data, 3); endproperty
   a_rd_fault: assert property (p_rd_fault) else $error("fault limit readback");
   property p_rd_warn; cmd_write && cmd_code == CMD_OT_WARNING_THRESHOLD ##1 (!cmd_write &&
      rd_code == CMD_OT_WARNING_THRESHOLD)[*3] |-> rd_data == $past(cmd_data, 3); endproperty
   a_rd_warn: assert property (p_rd_warn) else $error("warn limit readback");
   property p_warn; s_quiet [*3] |-> over_temp_warning == (temperature > warn_sh); endproperty
   a_warn: assert property (p_warn) else $error("warning flag");
   property p_ignore; act_sh[7:6] == REACT_IGNORE && output_enable && output_on_cmd &&
      !other_fault && !cmd_write |=> output_enable; endproperty
   a_ignore: assert property (p_ignore) else $error("ignore mode dropped output");
   property p_dis; $rose(over_temp_fault) && act_sh[7] |-> ##[0:2] !output_enable; endproperty
   a_dis: assert property (p_dis) else $error("output not disabled");
   property p_cont; $rose(over_temp_fault) && act_sh[7:6] == REACT_CONTINUE && output_enable &&
      act_sh[2:0] > 3'h1 && continue_unit_cycles > 24'h1 |=> output_enable [*4]; endproperty
   a_cont: assert property (p_cont) else $error("continue mode off early");
   property p_space; restart_attempt && restart_unit_cycles > 24'h1 && act_sh[2:0] != 3'h0
      |=> !restart_attempt [*3]; endproperty
   a_space: assert property (p_space) else $error("restarts too close");
   property p_none; (act_sh[5:3] == RETRY_NONE) [*8] |-> !restart_attempt; endproperty
   a_none: assert property (p_none) else $error("restart with retry 000");
   c_restart: cover property (restart_attempt);
   c_back_on: cover property (!output_enable ##1 output_enable);
   c_warn: cover property ($rose(over_temp_warning));
endmodule
bind otfr_over_temp_fault_response otfr_sva chk (.*);

/* dv/otfr_host.sv */
// host model: settings writes, reads and fault clears
`timescale 1ns/1ns
module otfr_host (
   input wire logic clk,
   input wire logic [15:0] rd_data,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_data,
   output logic [7:0] rd_code,
   output logic clear_faults,
   output logic clear_status_bit,
   output logic output_on_cmd
);
   // idle bus, output commanded on
   initial begin
      {cmd_write, clear_faults, clear_status_bit} = 3'h0;
      {cmd_code, rd_code, cmd_data, output_on_cmd} = 33'h1;
   end
   // one write cycle; released data shows junk, not the old word
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd_write <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      @(posedge clk);
      cmd_write <= 1'b0;
      cmd_data <= ~d;
   endtask
   // select, then take the word two edges on
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(posedge clk);
      rd_code <= c;
      repeat (2) @(posedge clk);
      #1;
      d = rd_data;
   endtask
   // clear pulse on either path plus off-then-on
   task automatic clr(input logic s);
      @(posedge clk);
      clear_faults <= !s;
      clear_status_bit <= s;
      output_on_cmd <= 1'b0;
      @(posedge clk);
      {clear_faults, clear_status_bit, output_on_cmd} <= 3'h1;
      repeat (4) @(posedge clk);
   endtask
endmodule

/* dv/tb_top.sv */
// testbench: settings access and fault reactions of the over-temp block
`timescale 1ns/1ns
module tb_top;
   import otfr_pkg::*;
   logic clk, arst_n, cmd_write, clear_faults, clear_status_bit, output_on_cmd, sel, last;
   logic restart_ok, other_fault, output_enable, over_temp_warning, over_temp_fault;
   logic restart_attempt;
   logic [7:0] cmd_code, rd_code;
   logic [15:0] cmd_data, rd_data, temperature, d;
   logic [UNIT_W-1:0] continue_unit_cycles, restart_unit_cycles;
   int failures, tests_run, cyc, att, on, gap, late;
   otfr_over_temp_fault_response dut (.*);
   otfr_host host (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, well above the run's length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // heat with one response byte; other fault may join halfway
   task automatic run(input logic [7:0] a, input int n, input logic of);
      int t1;
      host.wr(CMD_OT_FAULT_ACTION, {8'h00, a});
      temperature <= 16'h0200;
      {att, on, gap, late, t1} = '0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         other_fault <= of && i >= n / 2;
         #1;
         if (restart_attempt === 1'b1) begin
            if (att == 1) gap = i - t1;
            t1 = i;
            att++;
            late += (i > n / 2 + 4);
         end
         on += (output_enable === 1'b1);
      end
      last = output_enable;
      chk(16'(over_temp_fault), 16'h1);
      @(posedge clk);
      temperature <= 16'h0010;
      other_fault <= 1'b0;
      host.clr(sel);
      sel = ~sel;
      #1;
      chk(16'(output_enable), 16'h1);
   endtask
   initial begin
      {arst_n, restart_ok, other_fault, sel} = 4'h0;
      temperature = 16'h0010;
      continue_unit_cycles = 24'h2;
      restart_unit_cycles = 24'h2;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      host.rd(CMD_OT_FAULT_ACTION, d);
      chk(16'(d[7:0]), 16'(RST_FAULT_ACTION));
      host.rd(CMD_OT_FAULT_THRESHOLD, d);
      chk(d, RST_FAULT_THRESHOLD);
      // each limit is written while its own code is selected for read-back
      host.wr(CMD_OT_FAULT_THRESHOLD, 16'h0100);
      host.rd(CMD_OT_FAULT_THRESHOLD, d);
      chk(d, 16'h0100);
      host.rd(CMD_OT_WARNING_THRESHOLD, d);
      chk(d, RST_WARNING_THRESHOLD);
      host.wr(CMD_OT_WARNING_THRESHOLD, 16'h0080);
      host.rd(CMD_OT_WARNING_THRESHOLD, d);
      chk(d, 16'h0080);
      host.wr(8'h60, 16'h1234);
      host.rd(8'h60, d);
      chk(d, 16'h0000);
      @(posedge clk);
      temperature <= 16'h00c0;
      repeat (3) @(posedge clk);
      #1;
      chk(16'({over_temp_warning, over_temp_fault}), 16'h2);
      run(8'h00, 60, 1'b0);
      chk(16'(on + att), 16'd60);
      run(8'h42, 40, 1'b0);
      chk(16'(on > 7 && on < 14 && att == 0), 16'h1);
      run(8'hc1, 40, 1'b0);
      chk(16'(on < 3 && att == 0), 16'h1);
      // retry counts 0..6, all restarts failing
      for (int r = 0; r < 7; r++) begin
         run({2'h2, 3'(r), 3'h1}, 80, 1'b0);
         chk(16'(att), 16'(r));
         chk(16'(last), 16'h0);
         if (r > 1) chk(16'(gap), 16'd4);
      end
      // one retry that succeeds once the heat is gone brings the output back
      @(posedge clk);
      restart_ok <= 1'b1;
      host.wr(CMD_OT_FAULT_ACTION, 16'h0089);
      temperature <= 16'h0200;
      repeat (2) @(posedge clk);
      temperature <= 16'h0010;
      repeat (12) @(posedge clk);
      #1;
      chk(16'({output_enable, restart_attempt}), 16'h2);
      @(posedge clk);
      restart_unit_cycles <= 24'h3;
      run(8'hba, 200, 1'b1);
      chk(16'(gap), 16'd12);
      chk(16'(att > 6 && late == 0), 16'h1);
      close_out();
   end
endmodule
